// ==== include/resizer_pkg.sv ====
package resizer_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    ////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [11:0] OFF_IDENT = 12'hC00;
    localparam logic [11:0] OFF_RUN = 12'hC04;
    localparam logic [11:0] OFF_CFG = 12'hC08;

    ////////////////////////////////////////////////////////////////////
    // identification word layout
    localparam int TID_LSB = 16;
    localparam int CID_LSB = 8;
    localparam int REV_LSB = 0;

    // run control layout
    localparam int RUN_ENABLE_BIT = 0;
    localparam int RUN_BUSY_BIT = 1;

    // configuration layout
    localparam int CBIL_BIT = 29;
    localparam int SRC_BIT = 28;
    localparam int FMT_BIT = 27;
    localparam int ORDER_BIT = 26;
    localparam int VPH_LSB = 23;
    localparam int HPH_LSB = 20;
    localparam int VSC_LSB = 10;
    localparam int HSC_LSB = 0;
    localparam int PHASE_W = 3;
    localparam int SCALE_W = 10;
    localparam logic [9:0] SCALE_RESET = 10'h0FF;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h3FFF_FFFF;
    localparam logic [31:0] CFG_RESET =
        ({22'h0, SCALE_RESET} << VSC_LSB) | ({22'h0, SCALE_RESET} << HSC_LSB);

    ////////////////////////////////////////////////////////////////////
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic
    {
        SEQ_IDLE = 1'h0,
        SEQ_RUN = 1'h1
    } seq_state_e;

endpackage

// ==== include/reg_access_if.sv ====
`timescale 1ns/100ps
interface reg_access_if;
    logic wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;

    modport bus
    (
        output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        input wr_err, rd_data, rd_err
    );
    modport regs
    (
        input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        output wr_err, rd_data, rd_err
    );
endinterface

// ==== rtl/axi_lite_slave.sv ====
`timescale 1ns/100ps
module axi_lite_slave
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    reg_access_if.bus acc
);
    logic aw_full, next_aw_full;
    logic w_full, next_w_full;
    logic [11:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic do_write;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready = !w_full;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    // write fires once address and data are both held
    assign do_write = aw_full && w_full && !bvalid;
    assign acc.wr_en = do_write;
    assign acc.wr_addr = aw_addr;
    assign acc.wr_data = w_data;
    assign acc.wr_strb = w_strb;
    assign acc.rd_en = s_axi_arvalid && !rvalid;
    assign acc.rd_addr = s_axi_araddr;

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full = w_full;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_awvalid && !aw_full)
        begin
            next_aw_full = 1'h1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full)
        begin
            next_w_full = 1'h1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write)
        begin
            next_aw_full = 1'h0;
            next_w_full = 1'h0;
            next_bvalid = 1'h1;
            next_bresp = acc.wr_err ? resizer_pkg::RESP_SLVERR
                                    : resizer_pkg::RESP_OKAY;
        end
        else if (bvalid && s_axi_bready)
        begin
            next_bvalid = 1'h0;
        end
        if (acc.rd_en)
        begin
            next_rvalid = 1'h1;
            next_rdata = acc.rd_data;
            next_rresp = acc.rd_err ? resizer_pkg::RESP_SLVERR
                                    : resizer_pkg::RESP_OKAY;
        end
        else if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_full <= 1'h0;
            aw_addr <= 12'h000;
            w_full <= 1'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'h0;
            bresp <= 2'h0;
            rvalid <= 1'h0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
        end
        else
        begin
            aw_full <= next_aw_full;
            aw_addr <= next_aw_addr;
            w_full <= next_w_full;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end
endmodule

// ==== rtl/frame_sequencer.sv ====
`timescale 1ns/100ps
module frame_sequencer
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic frame_done,
    output logic launch,
    output logic busy,
    output logic frame_start
);
    resizer_pkg::seq_state_e state, next_state;
    logic next_frame_start;

    assign busy = (state == resizer_pkg::SEQ_RUN);
    // one frame per enable, next one only after the current ends
    assign launch = (state == resizer_pkg::SEQ_IDLE) && enable;
    assign next_frame_start = launch;

    always_comb
    begin
        case (state)
            resizer_pkg::SEQ_IDLE:
                next_state = launch ? resizer_pkg::SEQ_RUN
                                    : resizer_pkg::SEQ_IDLE;
            resizer_pkg::SEQ_RUN:
                next_state = frame_done ? resizer_pkg::SEQ_IDLE
                                        : resizer_pkg::SEQ_RUN;
            default:
                next_state = resizer_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= resizer_pkg::SEQ_IDLE;
            frame_start <= 1'h0;
        end
        else
        begin
            state <= next_state;
            frame_start <= next_frame_start;
        end
    end
endmodule

// ==== rtl/resizer_control_regs.sv ====
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
// Contract
// - identification word: type, class, revision bytes; top byte reads zero
// - busy bit 1 of run control reads 1 while a frame is processed
// - one frame at a time; each enable starts exactly one frame
// - hardware clears enable at the edge where busy becomes 1
// - enable may be written while busy, arming the next frame
// - bit 29 picks chroma method: 0 like luma, 1 bilinear
// - bit 27 picks format: 0 interleaved 4:2:2, 1 separate planes
// - bit 26 picks byte order: 0 luma first, 1 chroma first
// - bits 25:23 hold vertical start phase, any value 0 to 7
// - bits 22:20 hold horizontal start phase, any value 0 to 7
// - bits 19:10 hold vertical scale setting, ratio 256 over setting
// - bits 9:0 hold horizontal scale setting, ratio 256 over setting
// - after reset both scale fields are 255, other fields zero
module resizer_control_regs
#(
    // arbitrary neutral identification values
    parameter logic [7:0] PERIPHERAL_TYPE_ID = 8'hA5,
    parameter logic [7:0] CLASS_TYPE_ID = 8'h3C,
    parameter logic [7:0] REVISION_ID = 8'h01
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_done,
    output logic frame_start,
    output logic resizer_busy,
    output logic chroma_bilinear_select,
    output logic input_source_select,
    output logic input_format_select,
    output logic luma_chroma_order,
    output logic [2:0] vertical_start_phase,
    output logic [2:0] horizontal_start_phase,
    output logic [9:0] vertical_scale_setting,
    output logic [9:0] horizontal_scale_setting
);
    reg_access_if acc();

    logic enable, next_enable;
    logic [31:0] resize_configuration, next_resize_configuration;
    logic [31:0] active_configuration, next_active_configuration;
    logic launch;
    logic busy;
    logic sw_enable_write;
    logic [31:0] resizer_identification;
    logic [31:0] resizer_run_control;
    logic [31:0] merged_run;
    logic [31:0] read_word;
    logic [2:0] wr_sel;
    logic [2:0] rd_sel;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // one-hot hit: bit 0 identification, bit 1 run control, bit 2 config
    function automatic logic [2:0] reg_select(input logic [11:0] addr);
        logic [2:0] hit;
        case (addr)
            resizer_pkg::OFF_IDENT:
                hit = 3'h1;
            resizer_pkg::OFF_RUN:
                hit = 3'h2;
            resizer_pkg::OFF_CFG:
                hit = 3'h4;
            default:
                hit = 3'h0;
        endcase
        reg_select = hit;
    endfunction

    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = |reg_select(addr);
    endfunction

    function automatic logic [31:0] apply_strobe
    (
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] strb
    );
        logic [31:0] result;
        result = old_word;
        for (int i = 0; i < resizer_pkg::STRB_W; i++)
        begin
            if (strb[i])
            begin
                result[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        apply_strobe = result;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus slave and frame sequencing

    axi_lite_slave u_axi_lite_slave
    (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .acc(acc.bus)
    );

    frame_sequencer u_frame_sequencer
    (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .enable(enable),
        .frame_done(frame_done),
        .launch(launch),
        .busy(busy),
        .frame_start(frame_start)
    );

    ////////////////////////////////////////////////////////////////////
    // read-back words: identification and run control status

    always_comb
    begin
        resizer_identification = 32'h0000_0000;
        resizer_identification[resizer_pkg::TID_LSB +: 8] =
            PERIPHERAL_TYPE_ID;
        resizer_identification[resizer_pkg::CID_LSB +: 8] = CLASS_TYPE_ID;
        resizer_identification[resizer_pkg::REV_LSB +: 8] = REVISION_ID;
    end

    always_comb
    begin
        resizer_run_control = 32'h0000_0000;
        resizer_run_control[resizer_pkg::RUN_ENABLE_BIT] = enable;
        resizer_run_control[resizer_pkg::RUN_BUSY_BIT] = busy;
    end

    ////////////////////////////////////////////////////////////////////
    // write decode

    assign wr_sel = reg_select(acc.wr_addr);
    assign acc.wr_err = !is_mapped(acc.wr_addr);
    assign merged_run = apply_strobe(resizer_run_control, acc.wr_data,
                                     acc.wr_strb);
    // accepted whether busy or idle, so the next frame can be armed
    assign sw_enable_write = acc.wr_en
        && wr_sel[1]
        && acc.wr_strb[resizer_pkg::RUN_ENABLE_BIT / 8];

    always_comb
    begin
        next_enable = enable;
        if (launch)
        begin
            // cleared as busy rises
            next_enable = 1'h0;
        end
        if (sw_enable_write)
        begin
            // a software write in the launch cycle wins over the clear
            next_enable = merged_run[resizer_pkg::RUN_ENABLE_BIT];
        end
    end

    always_comb
    begin
        next_resize_configuration = resize_configuration;
        if (acc.wr_en && wr_sel[2])
        begin
            // every field takes any value; reserved bits stay zero
            next_resize_configuration =
                apply_strobe(resize_configuration, acc.wr_data, acc.wr_strb)
                & resizer_pkg::CFG_WRITE_MASK;
        end
    end

    // settings are frozen for the frame at its launch
    always_comb
    begin
        next_active_configuration = active_configuration;
        if (launch)
        begin
            next_active_configuration = resize_configuration;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enable <= 1'h0;
            resize_configuration <= resizer_pkg::CFG_RESET;
            active_configuration <= resizer_pkg::CFG_RESET;
        end
        else
        begin
            enable <= next_enable;
            resize_configuration <= next_resize_configuration;
            active_configuration <= next_active_configuration;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read decode

    assign rd_sel = reg_select(acc.rd_addr);

    // unmapped addresses read as zero
    always_comb
    begin
        read_word = 32'h0000_0000;
        if (rd_sel[0])
        begin
            read_word = resizer_identification;
        end
        if (rd_sel[1])
        begin
            read_word = resizer_run_control;
        end
        if (rd_sel[2])
        begin
            read_word = resize_configuration;
        end
    end

    assign acc.rd_data = read_word;
    assign acc.rd_err = !is_mapped(acc.rd_addr);

    ////////////////////////////////////////////////////////////////////
    // settings of the running frame

    assign resizer_busy = busy;
    assign chroma_bilinear_select =
        active_configuration[resizer_pkg::CBIL_BIT];
    assign input_source_select =
        active_configuration[resizer_pkg::SRC_BIT];
    assign input_format_select =
        active_configuration[resizer_pkg::FMT_BIT];
    assign luma_chroma_order =
        active_configuration[resizer_pkg::ORDER_BIT];
    assign vertical_start_phase =
        active_configuration[resizer_pkg::VPH_LSB +: 3];
    assign horizontal_start_phase =
        active_configuration[resizer_pkg::HPH_LSB +: 3];
    assign vertical_scale_setting =
        active_configuration[resizer_pkg::VSC_LSB +: 10];
    assign horizontal_scale_setting =
        active_configuration[resizer_pkg::HSC_LSB +: 10];

endmodule

// ==== testbench/frame_datapath_model.sv ====
`timescale 1ns/100ps
module frame_datapath_model
#(
    parameter int FRAME_CYCLES = 40
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic frame_start,
    output logic frame_done
);
    int remaining;

    // one completion pulse per started frame
    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            remaining <= 0;
            frame_done <= 1'b0;
        end
        else
        begin
            frame_done <= (remaining == 1);
            if (frame_start)
                remaining <= FRAME_CYCLES;
            else if (remaining > 0)
                remaining <= remaining - 1;
        end
    end
endmodule

// ==== testbench/resizer_control_regs_sva.sv ====
`timescale 1ns/100ps
module resizer_control_regs_sva
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic frame_done,
    input wire logic frame_start,
    input wire logic resizer_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_start_busy_rise: assert property (frame_start |-> resizer_busy
        && !$past(resizer_busy)) else $error("start not at busy rise");
    a_start_single: assert property (frame_start |=> !frame_start)
        else $error("start pulse too long");
    a_rise_has_start: assert property ($rose(resizer_busy) |->
        frame_start) else $error("busy rose without start");
    a_done_drops_busy: assert property (resizer_busy && frame_done
        |=> !resizer_busy) else $error("busy stayed after done");
    a_busy_holds: assert property (resizer_busy && !frame_done
        |=> resizer_busy) else $error("busy fell early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule

bind resizer_control_regs resizer_control_regs_sva chk
(
    .ref_clk(ref_clk), .reset_n(reset_n), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .frame_done(frame_done),
    .frame_start(frame_start), .resizer_busy(resizer_busy)
);

// ==== testbench/resizer_control_regs_tb.sv ====
`timescale 1ns/100ps
module resizer_control_regs_tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, frame_done;
    logic frame_start, resizer_busy;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [29:0] cfg_out;
    logic [31:0] lfsr = 32'h0000_001E;
    logic [31:0] cfg_val;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int errors = 0, n_checks = 0, frames = 0;

    always #25 ref_clk = ~ref_clk;

    resizer_control_regs uut
    (
        .ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .frame_done(frame_done),
        .frame_start(frame_start), .resizer_busy(resizer_busy),
        .chroma_bilinear_select(cfg_out[29]),
        .input_source_select(cfg_out[28]),
        .input_format_select(cfg_out[27]),
        .luma_chroma_order(cfg_out[26]),
        .vertical_start_phase(cfg_out[25:23]),
        .horizontal_start_phase(cfg_out[22:20]),
        .vertical_scale_setting(cfg_out[19:10]),
        .horizontal_scale_setting(cfg_out[9:0])
    );

    frame_datapath_model #(.FRAME_CYCLES(40)) far_side
    (
        .ref_clk(ref_clk), .reset_n(reset_n), .frame_start(frame_start),
        .frame_done(frame_done)
    );

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [33:0] exp,
        input logic [33:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] resp);
        bq.push_back(resp);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(bvalid && bready))
        begin
            @(posedge ref_clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] resp);
        rq.push_back({resp, d});
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!(rvalid && rready))
        begin
            @(posedge ref_clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic wait_start();
        while (frame_start !== 1'b1)
            @(negedge ref_clk);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // response monitor against queued expectations
    always @(posedge ref_clk)
    begin
        if (bvalid && bready && bq.size() > 0)
            check("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
        if (rvalid && rready && rq.size() > 0)
            check("rdata", rq.pop_front(), {rresp, rdata});
        if (frame_start === 1'b1)
            frames++;
    end

    initial
    begin
        #(50 * 20000);
        errors++;
        give_verdict();
    end

    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        check("cfg pins", 34'h0003_FCFF, {4'h0, cfg_out});
        axi_read(12'hC00, 32'h00A5_3C01, 2'h0);
        axi_read(12'hC04, 32'h0, 2'h0);
        axi_read(12'hC08, 32'h0003_FCFF, 2'h0);
        $display("test reset values done");
        axi_write(12'hC08, 32'hFFFF_FFFF, 4'hF, 2'h0);
        axi_read(12'hC08, 32'h3FFF_FFFF, 2'h0);
        for (int i = 0; i < 8; i++)
        begin
            lfsr = lfsr_next(lfsr);
            axi_write(12'hC08, lfsr, 4'hF, 2'h0);
            axi_read(12'hC08, lfsr & 32'h3FFF_FFFF, 2'h0);
        end
        cfg_val = lfsr & 32'h3FFF_FFFF;
        axi_write(12'hC08, 32'h0000_0000, 4'h1, 2'h0);
        axi_read(12'hC08, cfg_val & 32'hFFFF_FF00, 2'h0);
        $display("test configuration done");
        cfg_val = 32'h2A5A_5155;
        axi_write(12'hC08, cfg_val, 4'hF, 2'h0);
        axi_write(12'hC04, 32'h0000_0001, 4'hF, 2'h0);
        wait_start();
        check("cfg launch", {2'h0, cfg_val}, {4'h0, cfg_out});
        axi_read(12'hC04, 32'h0000_0002, 2'h0);
        axi_write(12'hC08, 32'h1424_67C3, 4'hF, 2'h0);
        axi_write(12'hC04, 32'h0000_0001, 4'hF, 2'h0);
        axi_read(12'hC04, 32'h0000_0003, 2'h0);
        check("cfg held", {2'h0, cfg_val}, {4'h0, cfg_out});
        @(posedge ref_clk);
        wait_start();
        check("cfg next", 34'h1424_67C3, {4'h0, cfg_out});
        repeat (60) @(posedge ref_clk);
        axi_read(12'hC04, 32'h0, 2'h0);
        check("frames", 34'h2, frames);
        $display("test frame sequence done");
        axi_write(12'hC00, 32'hFFFF_FFFF, 4'hF, 2'h0);
        axi_read(12'hC00, 32'h00A5_3C01, 2'h0);
        axi_write(12'hC04, 32'hFFFF_FFFE, 4'hF, 2'h0);
        axi_write(12'hC04, 32'h0000_0001, 4'h2, 2'h0);
        axi_read(12'hC04, 32'h0, 2'h0);
        axi_write(12'h100, 32'h1234_5678, 4'hF, 2'h2);
        axi_read(12'h100, 32'h0, 2'h2);
        repeat (5) @(posedge ref_clk);
        check("frames", 34'h2, frames);
        $display("test access kinds done");
        give_verdict();
    end
endmodule
